// file: hdl/vbc_cal_top.sv
`timescale 1ns/1ps
// Operation
// - code 0-3 gives n=code, 4-7 gives 5-8
// - worst case five measurements plus fixed overhead
// - internal serial port runs on state-machine clock
// - measurement counts reference edges, not state clocks
// - load fraction only after final switch settled, or after the single measurement when frozen
// - subsystem reached only through forwarding register
// - freeze holds switches, manual writes, mid-rail varactor
// - frozen calibration only measures, switches untouched
// - signed 20-bit count error stored by frozen runs only, bit 19 sign
// - integer write (integer mode) or fraction write (fractional mode) calibrates, or loads when disabled
// - k times 100 wait clocks before each measurement
// - state clock is reference over 2^m, m=0,2,4,5
// - expected count is floor of N times 2^n
module vbc_cal_top #(
  parameter int SW_W = 5
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ref_edge,
  input wire logic vco_edge,
  output logic vspi_clk,
  output logic vspi_data,
  output logic vspi_le,
  output logic [SW_W-1:0] vco_sw,
  output logic varactor_mid,
  output logic [vbc_pkg::INT_W-1:0] mod_int,
  output logic [vbc_pkg::FRAC_W-1:0] mod_frac,
  output logic mod_load
);

  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_SEND = 7'b0000010,
    S_WAIT = 7'b0000100,
    S_MEAS = 7'b0001000,
    S_DECIDE = 7'b0010000,
    S_FINAL = 7'b0100000,
    S_LOAD = 7'b1000000
  } vbc_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // state-machine clock divider

  logic [4:0] div_q, div_d;
  logic [4:0] div_top;
  logic tick;
  vbc_pkg::vbc_cfg_t cfg_q, cfg_d;

  always_comb begin
    div_top = 5'((6'h01 << vbc_pkg::m_from_sel(cfg_q.m_sel)) - 6'h01);
    tick = ref_edge && (div_q >= div_top);
    div_d = div_q;
    if (ref_edge) begin
      div_d = tick ? 5'h00 : div_q + 5'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_q <= 5'h00;
    end else begin
      div_q <= div_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file on the bus

  logic [vbc_pkg::REF_W-1:0] ref_div_q, ref_div_d;
  logic [vbc_pkg::INT_W-1:0] int_q, int_d;
  logic [vbc_pkg::FRAC_W-1:0] frac_q, frac_d;
  vbc_pkg::vbc_vspi_word_t fwd_q, fwd_d;
  logic mode_frac_q, mode_frac_d;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic [31:0] rd_word, wv;
  logic acc, stall, fwd_start, freq_wr, trig_set, imm_load, man_sw_wr;
  logic vs_busy;
  vbc_state_t st_q, st_d;
  logic [SW_W-1:0] sw_q, sw_d;
  logic [vbc_pkg::ERR_W-1:0] err_q, err_d;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (wb_adr_i)
      vbc_pkg::ADDR_REF_DIV: rd_word = 32'(ref_div_q);
      vbc_pkg::ADDR_INT: rd_word = 32'(int_q);
      vbc_pkg::ADDR_FRAC: rd_word = 32'(frac_q);
      vbc_pkg::ADDR_FWD: rd_word = 32'(fwd_q);
      vbc_pkg::ADDR_MODE: rd_word[vbc_pkg::MODE_FRAC_BIT] = mode_frac_q;
      vbc_pkg::ADDR_CAL_CFG: begin
        rd_word[vbc_pkg::CFG_N_LSB +: 3] = cfg_q.n_code;
        rd_word[vbc_pkg::CFG_K_LSB +: 2] = cfg_q.wait_k;
        rd_word[vbc_pkg::CFG_FREEZE_BIT] = cfg_q.freeze;
        rd_word[vbc_pkg::CFG_CAL_DIS_BIT] = cfg_q.cal_dis;
        rd_word[vbc_pkg::CFG_M_LSB +: 2] = cfg_q.m_sel;
      end
      vbc_pkg::ADDR_SW_STAT: begin
        rd_word[SW_W-1:0] = sw_q;
        // forwarded transfers count as busy, so polling this bit is enough
        rd_word[vbc_pkg::STAT_BUSY_BIT] = (st_q != S_IDLE) || vs_busy;
      end
      vbc_pkg::ADDR_BIST: rd_word = 32'(err_q);
      default: rd_word = 32'h0000_0000;
    endcase
    wv = vbc_pkg::lane_merge(rd_word, wb_dat_i, wb_sel_i);
    acc = wb_cyc_i && wb_stb_i && !ack_q;
    // forwarding waits until calibration is idle and the serial port has no transfer in flight
    stall = wb_we_i && (wb_adr_i == vbc_pkg::ADDR_FWD) && (vs_busy || st_q != S_IDLE);
    ack_d = acc && !stall;
    dat_d = (ack_d && !wb_we_i) ? rd_word : 32'h0000_0000;
    ref_div_d = ref_div_q;
    int_d = int_q;
    frac_d = frac_q;
    fwd_d = fwd_q;
    mode_frac_d = mode_frac_q;
    cfg_d = cfg_q;
    fwd_start = 1'b0;
    freq_wr = 1'b0;
    if (ack_d && wb_we_i) begin
      case (wb_adr_i)
        vbc_pkg::ADDR_REF_DIV: ref_div_d = wv[vbc_pkg::REF_W-1:0];
        vbc_pkg::ADDR_INT: begin
          int_d = wv[vbc_pkg::INT_W-1:0];
          freq_wr = !mode_frac_q;
        end
        vbc_pkg::ADDR_FRAC: begin
          frac_d = wv[vbc_pkg::FRAC_W-1:0];
          freq_wr = mode_frac_q;
        end
        vbc_pkg::ADDR_FWD: begin
          fwd_d = wv[15:0];
          fwd_start = 1'b1;
        end
        vbc_pkg::ADDR_MODE: mode_frac_d = wv[vbc_pkg::MODE_FRAC_BIT];
        vbc_pkg::ADDR_CAL_CFG: begin
          cfg_d.n_code = wv[vbc_pkg::CFG_N_LSB +: 3];
          cfg_d.wait_k = wv[vbc_pkg::CFG_K_LSB +: 2];
          cfg_d.freeze = wv[vbc_pkg::CFG_FREEZE_BIT];
          cfg_d.cal_dis = wv[vbc_pkg::CFG_CAL_DIS_BIT];
          cfg_d.m_sel = wv[vbc_pkg::CFG_M_LSB +: 2];
        end
        default: ;
      endcase
    end
    trig_set = freq_wr && !cfg_q.cal_dis;
    imm_load = freq_wr && cfg_q.cal_dis;
    man_sw_wr = fwd_start && (fwd_d.reg_addr == vbc_pkg::SW_REG_ADDR);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ref_div_q <= vbc_pkg::RST_REF_DIV;
      int_q <= vbc_pkg::RST_INT;
      frac_q <= vbc_pkg::RST_FRAC;
      fwd_q <= 16'h0000;
      mode_frac_q <= 1'b0;
      cfg_q <= '0;
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ref_div_q <= ref_div_d;
      int_q <= int_d;
      frac_q <= frac_d;
      fwd_q <= fwd_d;
      mode_frac_q <= mode_frac_d;
      cfg_q <= cfg_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  ////////////////////////////////////////////////////////////////////////////
  // calibration sequencer

  logic [2:0] bit_q, bit_d;
  logic [SW_W-1:0] res_q, res_d, trial;
  logic sent_q, sent_d, trig_q, trig_d, frz_q, frz_d;
  logic [8:0] wcnt_q, wcnt_d;
  logic [vbc_pkg::RCNT_W-1:0] rcnt_q, rcnt_d, rtarget;
  logic [vbc_pkg::MEAS_W-1:0] mcnt_q, mcnt_d, exp_cnt, diff;
  logic [vbc_pkg::INT_W+vbc_pkg::FRAC_W+7:0] n_scaled;
  logic [3:0] n_val;
  logic [vbc_pkg::INT_W-1:0] mod_int_q, mod_int_d;
  logic [vbc_pkg::FRAC_W-1:0] mod_frac_q, mod_frac_d;
  logic load_q, load_d, mid_q, mid_d, fsm_start;
  vbc_pkg::vbc_vspi_word_t cal_word, ser_word;

  always_comb begin
    n_val = vbc_pkg::n_from_code(cfg_q.n_code);
    n_scaled = {8'h00, int_q, frac_q} << n_val;
    exp_cnt = n_scaled[vbc_pkg::INT_W+vbc_pkg::FRAC_W+7:vbc_pkg::FRAC_W];
    rtarget = {8'h00, ref_div_q} << n_val;
    diff = mcnt_q - exp_cnt;
    trial = res_q | (SW_W'(1) << bit_q);
    st_d = st_q;
    bit_d = bit_q;
    res_d = res_q;
    sent_d = sent_q;
    wcnt_d = wcnt_q;
    rcnt_d = rcnt_q;
    mcnt_d = mcnt_q;
    err_d = err_q;
    frz_d = frz_q;
    sw_d = man_sw_wr ? SW_W'(fwd_d.data) : sw_q;
    mod_int_d = mod_int_q;
    mod_frac_d = mod_frac_q;
    load_d = 1'b0;
    fsm_start = 1'b0;
    // a new frequency write wins over the one being consumed
    trig_d = trig_set || trig_q;
    cal_word.data = 9'(st_q == S_FINAL ? res_q : trial);
    cal_word.reg_addr = vbc_pkg::SW_REG_ADDR;
    // selector kept from the forwarding register, never altered here
    cal_word.vco_subsystem_select = fwd_q.vco_subsystem_select;
    if (imm_load) begin
      mod_int_d = int_d;
      mod_frac_d = frac_d;
      load_d = 1'b1;
    end
    unique case (st_q)
      S_IDLE: begin
        if (trig_q) begin
          trig_d = trig_set;
          frz_d = cfg_q.freeze;
          bit_d = 3'(SW_W - 1);
          res_d = '0;
          sent_d = 1'b0;
          wcnt_d = 9'h000;
          st_d = cfg_q.freeze ? S_WAIT : S_SEND;
        end
      end
      S_SEND, S_FINAL: begin
        // a forwarded word still shifting would swallow the start
        if (!sent_q && !vs_busy) begin
          fsm_start = 1'b1;
          sent_d = 1'b1;
          if (st_q == S_SEND) begin
            sw_d = trial;
          end else begin
            sw_d = res_q;
          end
        end else if (sent_q && !vs_busy) begin
          sent_d = 1'b0;
          wcnt_d = 9'h000;
          st_d = (st_q == S_FINAL) ? S_LOAD : S_WAIT;
        end
      end
      S_WAIT: begin
        // open the window on a reference edge so no partial period is counted
        if ((wcnt_q >= 9'(cfg_q.wait_k) * 9'(vbc_pkg::WAIT_UNIT)) && ref_edge) begin
          rcnt_d = '0;
          mcnt_d = '0;
          st_d = S_MEAS;
        end else if (tick) begin
          wcnt_d = wcnt_q + 9'h001;
        end
      end
      S_MEAS: begin
        // gated by reference edges only, so the divider cannot bias the count
        if (rcnt_q >= rtarget) begin
          st_d = S_DECIDE;
        end else begin
          if (ref_edge) begin
            rcnt_d = rcnt_q + 1'b1;
          end
          if (vco_edge) begin
            mcnt_d = mcnt_q + 1'b1;
          end
        end
      end
      S_DECIDE: begin
        if (frz_q) begin
          err_d = diff[vbc_pkg::ERR_W-1:0];
          st_d = S_LOAD;
        end else begin
          // higher switch code lowers the frequency: keep the bit while too fast
          if (mcnt_q > exp_cnt) begin
            res_d = trial;
          end
          if (bit_q == 3'h0) begin
            st_d = S_FINAL;
          end else begin
            bit_d = bit_q - 3'h1;
            st_d = S_SEND;
          end
        end
      end
      S_LOAD: begin
        mod_int_d = int_q;
        mod_frac_d = frac_q;
        load_d = 1'b1;
        st_d = S_IDLE;
      end
    endcase
    mid_d = cfg_q.freeze || (st_d != S_IDLE);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= S_IDLE;
      bit_q <= 3'h0;
      res_q <= '0;
      sent_q <= 1'b0;
      trig_q <= 1'b0;
      frz_q <= 1'b0;
      wcnt_q <= 9'h000;
      rcnt_q <= '0;
      mcnt_q <= '0;
      err_q <= '0;
      sw_q <= '0;
      mod_int_q <= vbc_pkg::RST_INT;
      mod_frac_q <= vbc_pkg::RST_FRAC;
      load_q <= 1'b0;
      mid_q <= 1'b0;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      res_q <= res_d;
      sent_q <= sent_d;
      trig_q <= trig_d;
      frz_q <= frz_d;
      wcnt_q <= wcnt_d;
      rcnt_q <= rcnt_d;
      mcnt_q <= mcnt_d;
      err_q <= err_d;
      sw_q <= sw_d;
      mod_int_q <= mod_int_d;
      mod_frac_q <= mod_frac_d;
      load_q <= load_d;
      mid_q <= mid_d;
    end
  end

  assign vco_sw = sw_q;
  assign varactor_mid = mid_q;
  assign mod_int = mod_int_q;
  assign mod_frac = mod_frac_q;
  assign mod_load = load_q;
  assign ser_word = fsm_start ? cal_word : fwd_d;

  ////////////////////////////////////////////////////////////////////////////
  // internal oscillator-subsystem serial port

  vbc_vspi_ser u_ser (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick),
    .start(fsm_start || fwd_start),
    .word(ser_word),
    .busy(vs_busy),
    .vspi_clk(vspi_clk),
    .vspi_data(vspi_data),
    .vspi_le(vspi_le)
  );

endmodule

// file: hdl/vbc_pkg.sv
package vbc_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] ADDR_REF_DIV = 8'h08;
  localparam logic [7:0] ADDR_INT = 8'h0c;
  localparam logic [7:0] ADDR_FRAC = 8'h10;
  localparam logic [7:0] ADDR_FWD = 8'h14;
  localparam logic [7:0] ADDR_MODE = 8'h18;
  localparam logic [7:0] ADDR_CAL_CFG = 8'h28;
  localparam logic [7:0] ADDR_SW_STAT = 8'h40;
  localparam logic [7:0] ADDR_BIST = 8'h44;

  // field positions
  localparam int CFG_N_LSB = 0;
  localparam int CFG_K_LSB = 6;
  localparam int CFG_FREEZE_BIT = 10;
  localparam int CFG_CAL_DIS_BIT = 11;
  localparam int CFG_M_LSB = 13;
  localparam int MODE_FRAC_BIT = 11;
  localparam int STAT_BUSY_BIT = 8;

  // widths
  localparam int REF_W = 14;
  localparam int INT_W = 19;
  localparam int FRAC_W = 24;
  localparam int ERR_W = 20;
  localparam int MEAS_W = INT_W + 8;
  localparam int RCNT_W = REF_W + 8;

  // reset values
  localparam logic [REF_W-1:0] RST_REF_DIV = 14'h0001;
  localparam logic [INT_W-1:0] RST_INT = 19'h00000;
  localparam logic [FRAC_W-1:0] RST_FRAC = 24'h000000;

  // timing counts in state-machine clocks
  localparam logic [6:0] WAIT_UNIT = 7'h64;
  localparam int VSPI_BITS = 16;
  localparam logic [4:0] VSPI_CYCLES = 5'h14;

  // oscillator-subsystem register that holds the band switches
  localparam logic [3:0] SW_REG_ADDR = 4'h0;

  typedef struct packed {
    logic [1:0] m_sel;
    logic cal_dis;
    logic freeze;
    logic [1:0] wait_k;
    logic [2:0] n_code;
  } vbc_cfg_t;

  typedef struct packed {
    logic [8:0] data;
    logic [3:0] reg_addr;
    logic [2:0] vco_subsystem_select;
  } vbc_vspi_word_t;

  // measurement-length code to count exponent
  function automatic logic [3:0] n_from_code(input logic [2:0] code);
    n_from_code = code[2] ? {2'b00, code[1:0]} + 4'h5 : {2'b00, code[1:0]};
  endfunction

  // divider select to exponent m
  function automatic logic [2:0] m_from_sel(input logic [1:0] sel);
    case (sel)
      2'h0: m_from_sel = 3'h0;
      2'h1: m_from_sel = 3'h2;
      2'h2: m_from_sel = 3'h4;
      default: m_from_sel = 3'h5;
    endcase
  endfunction

  // byte-lane merge for classic wishbone writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      lane_merge[i*8 +: 8] = sel[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction

endpackage

// file: hdl/vbc_vspi_ser.sv
`timescale 1ns/1ps
// shifts one 16-bit word to the oscillator subsystem, one bit per
// state-machine clock; a transfer occupies 20 such clocks in total
module vbc_vspi_ser (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic start,
  input wire vbc_pkg::vbc_vspi_word_t word,
  output logic busy,
  output logic vspi_clk,
  output logic vspi_data,
  output logic vspi_le
);

  logic busy_q, busy_d;
  logic [4:0] cnt_q, cnt_d;
  logic [15:0] sh_q, sh_d;
  logic arm_q, arm_d;
  logic sclk_q, sclk_d;
  logic data_q, data_d;
  logic le_q, le_d;

  always_comb begin
    busy_d = busy_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    data_d = data_q;
    arm_d = 1'b0;
    sclk_d = arm_q;
    le_d = 1'b0;
    if (!busy_q) begin
      if (start) begin
        busy_d = 1'b1;
        sh_d = word;
        cnt_d = 5'h00;
      end
    end else if (tick) begin
      if (cnt_q < 5'(vbc_pkg::VSPI_BITS)) begin
        data_d = sh_q[15];
        sh_d = {sh_q[14:0], 1'b0};
        // clock edge follows data by one core cycle for setup
        arm_d = 1'b1;
      end
      if (cnt_q == vbc_pkg::VSPI_CYCLES - 5'h01) begin
        busy_d = 1'b0;
        le_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      cnt_q <= 5'h00;
      sh_q <= 16'h0000;
      arm_q <= 1'b0;
      sclk_q <= 1'b0;
      data_q <= 1'b0;
      le_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      arm_q <= arm_d;
      sclk_q <= sclk_d;
      data_q <= data_d;
      le_q <= le_d;
    end
  end

  assign busy = busy_q;
  assign vspi_clk = sclk_q;
  assign vspi_data = data_q;
  assign vspi_le = le_q;

endmodule

// file: sim/vbc_osc_model.sv
`timescale 1ns/1ps
// oscillator side: reference pulses, a switch-dependent oscillator rate,
// and a receiver for the internal serial port
module vbc_osc_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic vspi_clk,
  input wire logic vspi_data,
  input wire logic vspi_le,
  output logic ref_edge,
  output logic vco_edge,
  output logic [15:0] last_word,
  output logic [4:0] sw_q
);
  logic [15:0] shift_q;
  logic [3:0] phase_q;
  logic [3:0] span;
  // switch 0 is the fastest band; pulses never meet the reference pulse
  assign span = 4'd14 - {1'b0, sw_q[4:2]};
  always @(posedge core_clk) begin
    if (rst) begin
      shift_q <= 16'h0000;
      last_word <= 16'h0000;
      sw_q <= 5'h00;
      phase_q <= 4'h0;
      ref_edge <= 1'b0;
      vco_edge <= 1'b0;
    end else begin
      phase_q <= phase_q + 4'h1;
      ref_edge <= (phase_q == 4'hf);
      vco_edge <= (phase_q < span);
      if (vspi_clk) begin
        shift_q <= {shift_q[14:0], vspi_data};
      end
      if (vspi_le) begin
        last_word <= shift_q;
        if (shift_q[6:3] == 4'h0) begin
          sw_q <= shift_q[11:7];
        end
      end
    end
  end
endmodule

// file: sim/vbc_cal_top_assertions.sv
`timescale 1ns/1ps
module vbc_cal_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic vspi_clk,
  input wire logic vspi_le,
  input wire logic [18:0] mod_int,
  input wire logic [23:0] mod_frac,
  input wire logic mod_load
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_req; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack without request");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_load_pulse; mod_load |=> !mod_load; endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load longer than one cycle");
  property p_mod_hold; !mod_load |-> $stable(mod_frac) && $stable(mod_int); endproperty
  a_mod_hold: assert property (p_mod_hold) else $error("modulator moved without load");
  property p_le_pulse; vspi_le |=> !vspi_le; endproperty
  a_le_pulse: assert property (p_le_pulse) else $error("latch pulse too long");
  property p_le_clk; vspi_le |-> !vspi_clk && !$past(vspi_clk); endproperty
  a_le_clk: assert property (p_le_clk) else $error("latch overlaps shifting");
  property p_clk_gap; vspi_clk |=> !vspi_clk; endproperty
  a_clk_gap: assert property (p_clk_gap) else $error("serial clock held high");
endmodule

bind vbc_cal_top vbc_cal_chk u_chk (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .vspi_clk(vspi_clk),
  .vspi_le(vspi_le), .mod_int(mod_int), .mod_frac(mod_frac), .mod_load(mod_load));

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q, v;
  logic ack, ref_edge, vco_edge, vclk, vdat, vle, vmid, mload;
  logic [4:0] vsw, msw, s;
  logic [18:0] mint;
  logic [23:0] mfrac, f;
  logic [15:0] lword, w;
  int err_count = 0;
  int compares = 0;
  int loads = 0;
  integer seed = 32'hc0fd9626;
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (mload === 1'b1) loads <= loads + 1;
  vbc_cal_top u_dut (.core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .ref_edge(ref_edge), .vco_edge(vco_edge), .vspi_clk(vclk),
    .vspi_data(vdat), .vspi_le(vle), .vco_sw(vsw), .varactor_mid(vmid), .mod_int(mint),
    .mod_frac(mfrac), .mod_load(mload));
  vbc_osc_model u_osc (.core_clk(core_clk), .rst(rst), .vspi_clk(vclk), .vspi_data(vdat),
    .vspi_le(vle), .ref_edge(ref_edge), .vco_edge(vco_edge), .last_word(lword), .sw_q(msw));
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle; waits up to 40000 cycles for ack while a forward write is held off
  task automatic wb(input logic w_en, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_en;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 40000);
    if (n >= 40000) err_count++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic settle();
    int n;
    n = 0;
    do begin
      wb(1'b0, vbc_pkg::ADDR_SW_STAT, 32'h0);
      n++;
    end while (q[vbc_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 3000);
    repeat (4) @(posedge core_clk);
  endtask
  task automatic wait_load(input int l0);
    int n;
    n = 0;
    while (loads == l0 && n < 60000) begin
      @(posedge core_clk);
      n++;
    end
    repeat (2) @(posedge core_clk);
    chk(32'(loads - l0), 32'h1);
  endtask
  function automatic int nexp(input int c);
    return (c < 4) ? c : c + 1;
  endfunction
  function automatic logic [31:0] exp_v(input logic [18:0] ni, input logic [23:0] nf,
                                        input int n);
    logic [55:0] p;
    p = ({13'h0, ni, 24'h0} | {32'h0, nf}) << n;
    return p[55:24];
  endfunction
  // trial bit kept while the oscillator still counts above the target
  function automatic logic [4:0] exp_sw(input logic [31:0] tv, input int n);
    logic [4:0] acc;
    logic [4:0] t;
    acc = 5'h00;
    for (int b = 4; b >= 0; b--) begin
      t = acc | (5'h01 << b);
      if ((32'(4'd14 - {1'b0, t[4:2]}) << n) > tv) acc = t;
    end
    return acc;
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge core_clk);
    err_count++;
    wrap_up();
  end
  initial begin
    int l0;
    int r;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    wb(1'b0, vbc_pkg::ADDR_REF_DIV, 32'h0);
    chk(q, 32'h1);
    wb(1'b1, 8'h3c, 32'hffffffff);
    wb(1'b0, 8'h3c, 32'h0);
    chk(q, 32'h0);
    // mute sequence, then a random band switch with selector zero
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      w = (i == 0) ? 16'h0218 : (i == 1) ? 16'h0608 :
          (i == 2) ? 16'h0208 : {4'h0, r[4:0], 7'h0};
      wb(1'b1, vbc_pkg::ADDR_FWD, {16'h0, w});
      settle();
      chk({16'h0, lword}, {16'h0, w});
    end
    chk({27'h0, vsw}, {27'h0, r[4:0]});
    wb(1'b1, vbc_pkg::ADDR_FWD, 32'h0);
    settle();
    wb(1'b1, vbc_pkg::ADDR_CAL_CFG, 32'h800);
    wb(1'b1, vbc_pkg::ADDR_MODE, 32'h0);
    r = $random(seed);
    l0 = loads;
    wb(1'b1, vbc_pkg::ADDR_INT, {13'h0, r[18:0]});
    wait_load(l0);
    chk({13'h0, mint}, {13'h0, r[18:0]});
    wb(1'b1, vbc_pkg::ADDR_MODE, 32'h800);
    l0 = loads;
    wb(1'b1, vbc_pkg::ADDR_INT, 32'd13);
    f = 24'($random(seed));
    wb(1'b1, vbc_pkg::ADDR_FRAC, {8'h0, f});
    wait_load(l0);
    chk({8'h0, mfrac}, {8'h0, f});
    // frozen runs over every length code; slow state clock only without waits
    for (int c = 0; c < 8; c++) begin
      r = $random(seed);
      wb(1'b1, vbc_pkg::ADDR_INT, 32'(13 + c % 2));
      wb(1'b1, vbc_pkg::ADDR_CAL_CFG, {18'h0, r[0], 6'h8, ~r[0] & r[1], 6'(c)});
      chk({31'h0, vmid}, 32'h1);
      f = r[31:8];
      l0 = loads;
      wb(1'b1, vbc_pkg::ADDR_FRAC, {8'h0, f});
      wait_load(l0);
      v = (32'd14 << nexp(c)) - exp_v(19'(13 + c % 2), f, nexp(c));
      wb(1'b0, vbc_pkg::ADDR_BIST, 32'h0);
      chk(q, {12'h0, v[19:0]});
      chk({27'h0, vsw}, 32'h0);
    end
    wb(1'b1, vbc_pkg::ADDR_CAL_CFG, 32'h1);
    chk({31'h0, vmid}, 32'h0);
    wb(1'b1, vbc_pkg::ADDR_INT, 32'd10);
    f = 24'($random(seed));
    l0 = loads;
    wb(1'b1, vbc_pkg::ADDR_FRAC, {8'h0, f});
    wait_load(l0);
    s = exp_sw(exp_v(19'd10, f, 1), 1);
    chk({27'h0, vsw}, {27'h0, s});
    chk({27'h0, msw}, {27'h0, s});
    chk({16'h0, lword}, {20'h0, s, 7'h0});
    chk({8'h0, mfrac}, {8'h0, f});
    wrap_up();
  end
endmodule
